// File: shared/sfr_cfg.svh
`ifndef SFR_CFG_SVH
`define SFR_CFG_SVH

// ----------------------------------------
// Controller register map (word offsets on the software port)
// ----------------------------------------
`define SFR_OFF_CMD 4'h0
`define SFR_OFF_CTRL 4'h1
`define SFR_OFF_STATUS 4'h2
`define SFR_OFF_RESP 4'h3
`define SFR_OFF_SUMMARY 4'h4
`define SFR_OFF_THERMAL 4'h5
`define SFR_OFF_POWER 4'h6

// ----------------------------------------
// Command register fields
// ----------------------------------------
`define SFR_CMD_RW_BIT 15
`define SFR_CMD_ADDR_HI 14
`define SFR_CMD_ADDR_LO 9
`define SFR_CMD_PAR_BIT 8

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SFR_CTRL_START_BIT 0
`define SFR_CTRL_PULSE_BIT 1
`define SFR_CTRL_SLEEP_BIT 2

// ----------------------------------------
// Device map
// ----------------------------------------
`define SFR_DEV_SUMMARY 6'h00
`define SFR_DEV_THERMAL 6'h01
`define SFR_DEV_POWER 6'h02
`define SFR_DEV_LAST 6'h0C
`define SFR_FRAME_BITS 16

// ----------------------------------------
// Timing
// ----------------------------------------
`define SFR_CLK_HZ 10000000
`define SFR_SCLK_HALF_CYC 4
`define SFR_CS_GAP_NS 400
`define SFR_CS_GAP_CYC ((`SFR_CS_GAP_NS * (`SFR_CLK_HZ / 1000000) + 999) / 1000)
`define SFR_RST_LOW_CYC 10

`endif

// File: shared/sfr_pkg.sv
package sfr_pkg;
  typedef enum logic [4:0] {
    SFR_IDLE = 5'b00001,
    SFR_LEAD = 5'b00010,
    SFR_SHIFT = 5'b00100,
    SFR_TAIL = 5'b01000,
    SFR_GAP = 5'b10000
  } sfr_state_t;
  typedef logic [15:0] sfr_word_t;
endpackage

// File: design/sfr_sleep_pulse.sv
`timescale 1ns/10ps
`include "sfr_cfg.svh"

module sfr_sleep_pulse #(
  parameter int LOW_CYC = `SFR_RST_LOW_CYC
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Control.
  input wire logic pulseReq,
  input wire logic sleepHold,
  // Pin and status.
  output logic sleepPinActiveLow,
  output logic pulseBusy
);
  import sfr_pkg::*;

  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic next_pin;
  logic next_busy;

  // --------------------------------
  // Pulse timing
  // --------------------------------
  // The low phase is kept short so the device clears faults instead of shutting down.
  always_comb begin
    next_cnt = cnt;
    next_busy = pulseBusy;
    next_pin = 1'b1;
    if (pulseBusy) begin
      next_pin = 1'b0;
      if (cnt == 16'(LOW_CYC - 1)) begin
        next_busy = 1'b0;
        next_pin = 1'b1;
        next_cnt = 16'h0000;
      end else begin
        next_cnt = cnt + 16'h0001;
      end
    end else if (pulseReq && !sleepHold) begin
      next_busy = 1'b1;
      next_pin = 1'b0;
      next_cnt = 16'h0000;
    end
    if (sleepHold) begin
      next_pin = 1'b0;
    end
  end

  // Registers of the pulse generator.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt <= 16'h0000;
      pulseBusy <= 1'b0;
      sleepPinActiveLow <= 1'b1;
    end else begin
      cnt <= next_cnt;
      pulseBusy <= next_busy;
      sleepPinActiveLow <= next_pin;
    end
  end
endmodule // sfr_sleep_pulse

// File: design/sfr_host.sv
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
`include "sfr_cfg.svh"

module sfr_host #(
  parameter int HALF_CYC = `SFR_SCLK_HALF_CYC,
  parameter int LOW_CYC = `SFR_RST_LOW_CYC
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Software port.
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  // Serial link to the device.
  output logic chipSelectActiveLow,
  output logic serialClock,
  output logic serialOut,
  input wire logic serialIn,
  // Sleep pin.
  output logic sleepPinActiveLow
);
  import sfr_pkg::*;

  localparam int GAP_CYC = (`SFR_CS_GAP_CYC < 1) ? 1 : `SFR_CS_GAP_CYC;

  sfr_state_t state;
  sfr_state_t next_state;
  sfr_pkg::sfr_word_t cmd;
  sfr_pkg::sfr_word_t next_cmd;
  sfr_pkg::sfr_word_t txShift;
  sfr_pkg::sfr_word_t next_txShift;
  sfr_pkg::sfr_word_t rxShift;
  sfr_pkg::sfr_word_t next_rxShift;
  sfr_pkg::sfr_word_t resp;
  sfr_pkg::sfr_word_t next_resp;
  logic [7:0] summary;
  logic [7:0] next_summary;
  logic [7:0] thermal;
  logic [7:0] next_thermal;
  logic [7:0] power;
  logic [7:0] next_power;
  logic [7:0] tick;
  logic [7:0] next_tick;
  logic [4:0] bitCnt;
  logic [4:0] next_bitCnt;
  logic busy;
  logic next_busy;
  logic done;
  logic next_done;
  logic sleepHold;
  logic next_sleepHold;
  logic [15:0] next_rdata;
  logic next_cs;
  logic next_sclk;
  logic next_sdo;
  logic sdiMeta;
  logic sdiSync;
  logic pulseReq;
  logic pulseBusy;
  logic startReq;

  // --------------------------------
  // Input synchroniser
  // --------------------------------
  // The response pin comes from the device domain.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sdiMeta <= 1'b0;
      sdiSync <= 1'b0;
    end else begin
      sdiMeta <= serialIn;
      sdiSync <= sdiMeta;
    end
  end

  // Writes to the control register start frames and pulses.
  // fault clear pulse request
  assign startReq = regWr && (regAddr == `SFR_OFF_CTRL) && regWdata[`SFR_CTRL_START_BIT];
  assign pulseReq = regWr && (regAddr == `SFR_OFF_CTRL) && regWdata[`SFR_CTRL_PULSE_BIT];

  sfr_sleep_pulse #(
    .LOW_CYC(LOW_CYC)
  ) u_pulse (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pulseReq(pulseReq),
    .sleepHold(sleepHold),
    .sleepPinActiveLow(sleepPinActiveLow),
    .pulseBusy(pulseBusy)
  );

  // --------------------------------
  // Frame engine
  // --------------------------------
  // A frame is only started from idle so a write during a frame cannot corrupt it.
  always_comb begin
    next_state = state;
    next_cmd = cmd;
    next_txShift = txShift;
    next_rxShift = rxShift;
    next_resp = resp;
    next_summary = summary;
    next_thermal = thermal;
    next_power = power;
    next_tick = tick;
    next_bitCnt = bitCnt;
    next_busy = busy;
    next_done = done;
    next_sleepHold = sleepHold;
    next_cs = chipSelectActiveLow;
    next_sclk = serialClock;
    next_sdo = serialOut;
    if (regWr && regAddr == `SFR_OFF_CMD && !busy) begin
      next_cmd = regWdata;
      next_cmd[`SFR_CMD_PAR_BIT] = ^{regWdata[15:9], regWdata[7:0]};
    end
    if (regWr && regAddr == `SFR_OFF_CTRL) begin
      next_sleepHold = regWdata[`SFR_CTRL_SLEEP_BIT];
      if (regWdata[`SFR_CTRL_START_BIT]) begin
        next_done = 1'b0;
      end
    end
    if (sleepHold) begin
      next_summary = 8'h00;
      next_thermal = 8'h00;
      next_power = 8'h00;
    end
    case (state)
      SFR_IDLE: begin
        next_cs = 1'b1;
        next_sclk = 1'b0;
        if (startReq && !sleepHold) begin
          next_busy = 1'b1;
          next_txShift = next_cmd;
          next_cs = 1'b0;
          next_sclk = 1'b0;
          next_tick = 8'h00;
          next_bitCnt = 5'h00;
          next_state = SFR_LEAD;
        end
      end
      SFR_LEAD: begin
        if (tick == 8'(HALF_CYC - 1)) begin
          next_tick = 8'h00;
          next_sclk = 1'b1;
          next_sdo = txShift[15];
          next_txShift = {txShift[14:0], 1'b0};
          next_state = SFR_SHIFT;
        end else begin
          next_tick = tick + 8'h01;
        end
      end
      SFR_SHIFT: begin
        if (tick == 8'(HALF_CYC - 1)) begin
          next_tick = 8'h00;
          if (serialClock) begin
            next_sclk = 1'b0;
            next_rxShift = {rxShift[14:0], sdiSync};
            next_bitCnt = bitCnt + 5'h01;
            if (bitCnt == 5'(`SFR_FRAME_BITS - 1)) begin
              next_state = SFR_TAIL;
            end
          end else begin
            next_sclk = 1'b1;
            next_sdo = txShift[15];
            next_txShift = {txShift[14:0], 1'b0};
          end
        end else begin
          next_tick = tick + 8'h01;
        end
      end
      SFR_TAIL: begin
        if (tick == 8'(HALF_CYC - 1)) begin
          next_tick = 8'h00;
          next_cs = 1'b1;
          next_sdo = 1'b0;
          next_resp = rxShift;
          if (cmd[`SFR_CMD_RW_BIT]) begin
            case (cmd[`SFR_CMD_ADDR_HI:`SFR_CMD_ADDR_LO])
              `SFR_DEV_SUMMARY: next_summary = rxShift[7:0];
              `SFR_DEV_THERMAL: next_thermal = rxShift[7:0];
              `SFR_DEV_POWER: next_power = rxShift[7:0];
              default: next_power = power;
            endcase
          end
          next_state = SFR_GAP;
        end else begin
          next_tick = tick + 8'h01;
        end
      end
      SFR_GAP: begin
        if (tick == 8'(GAP_CYC - 1)) begin
          next_tick = 8'h00;
          next_busy = 1'b0;
          next_done = 1'b1;
          next_state = SFR_IDLE;
        end else begin
          next_tick = tick + 8'h01;
        end
      end
      default: begin
        next_state = SFR_IDLE;
        next_cs = 1'b1;
        next_sclk = 1'b0;
        next_busy = 1'b0;
      end
    endcase
  end

  // --------------------------------
  // Software read mux
  // --------------------------------
  // Status shows busy, done, pulse, the fault bit of the last status byte and the low three bits of the power register.
  always_comb begin
    next_rdata = 16'h0000;
    if (regRd) begin
      case (regAddr)
        `SFR_OFF_CMD: next_rdata = cmd;
        `SFR_OFF_CTRL: next_rdata = {13'h0000, sleepHold, 2'b00};
        `SFR_OFF_STATUS: next_rdata = {8'h00, power[2:0], resp[13], 1'b0, pulseBusy, done, busy};
        `SFR_OFF_RESP: next_rdata = resp;
        `SFR_OFF_SUMMARY: next_rdata = {8'h00, summary};
        `SFR_OFF_THERMAL: next_rdata = {8'h00, thermal};
        `SFR_OFF_POWER: next_rdata = {8'h00, power};
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= SFR_IDLE;
      cmd <= 16'h0000;
      txShift <= 16'h0000;
      rxShift <= 16'h0000;
      resp <= 16'h0000;
      summary <= 8'h00;
      thermal <= 8'h00;
      power <= 8'h00;
      tick <= 8'h00;
      bitCnt <= 5'h00;
      busy <= 1'b0;
      done <= 1'b0;
      sleepHold <= 1'b0;
      regRdata <= 16'h0000;
      chipSelectActiveLow <= 1'b1;
      serialClock <= 1'b0;
      serialOut <= 1'b0;
    end else begin
      state <= next_state;
      cmd <= next_cmd;
      txShift <= next_txShift;
      rxShift <= next_rxShift;
      resp <= next_resp;
      summary <= next_summary;
      thermal <= next_thermal;
      power <= next_power;
      tick <= next_tick;
      bitCnt <= next_bitCnt;
      busy <= next_busy;
      done <= next_done;
      sleepHold <= next_sleepHold;
      regRdata <= next_rdata;
      chipSelectActiveLow <= next_cs;
      serialClock <= next_sclk;
      serialOut <= next_sdo;
    end
  end
endmodule // sfr_host

// File: sim/sfr_host_properties.sv
`timescale 1ns/10ps

// ----------------------------------------
// Link and sleep pin timing checks
// ----------------------------------------
module sfr_host_properties #(
  parameter int HALF_CYC = 4,
  parameter int LOW_CYC = 10
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Link and sleep pin.
  input wire logic chipSelectActiveLow,
  input wire logic serialClock,
  input wire logic serialOut,
  input wire logic sleepPinActiveLow
);
  logic [7:0] age, next_age, falls, next_falls, lowCnt, next_lowCnt;
  logic prevCs, prevSclk;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // Age of the last link edge saturates, so a long idle never wraps into a match.
  always_comb begin
    next_age = (age == 8'hFF) ? age : age + 8'h01;
    if (prevCs != chipSelectActiveLow || prevSclk != serialClock) next_age = 8'h01;
    next_falls = (prevSclk && !serialClock) ? falls + 8'h01 : falls;
    if (prevCs && !chipSelectActiveLow) next_falls = 8'h00;
    next_lowCnt = sleepPinActiveLow ? 8'h00 : lowCnt + 8'h01;
  end

  // Helper registers.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      age <= 8'h00;
      falls <= 8'h00;
      lowCnt <= 8'h00;
      prevCs <= 1'h1;
      prevSclk <= 1'h0;
    end else begin
      age <= next_age;
      falls <= next_falls;
      lowCnt <= next_lowCnt;
      prevCs <= chipSelectActiveLow;
      prevSclk <= serialClock;
    end
  end

  sclk_at_cs_a: assert property ($changed(chipSelectActiveLow) |->
    !serialClock && !$past(serialClock)) else $error("clock high at select edge");
  sclk_idle_a: assert property (chipSelectActiveLow |-> !serialClock)
    else $error("clock moves while deselected");
  sdo_launch_a: assert property (!chipSelectActiveLow && $changed(serialOut)
    |-> $rose(serialClock)) else $error("data changed off rising clock");
  cs_gap_a: assert property ($rose(chipSelectActiveLow) |-> chipSelectActiveLow[*4])
    else $error("deselect gap too short");
  half_period_a: assert property ($changed(serialClock) |-> age == HALF_CYC)
    else $error("clock phase length wrong");
  tail_len_a: assert property ($rose(chipSelectActiveLow) |-> age == HALF_CYC)
    else $error("deselect not one phase after last fall");
  bit_count_a: assert property ($rose(chipSelectActiveLow) |-> falls == 8'h10)
    else $error("frame not sixteen clocks");
  pulse_len_a: assert property ($rose(sleepPinActiveLow) |-> lowCnt == LOW_CYC)
    else $error("reset pulse length wrong");

  frame_c: cover property ($rose(chipSelectActiveLow));
  pulse_c: cover property ($rose(sleepPinActiveLow));
  data_one_c: cover property (!chipSelectActiveLow && serialOut);
endmodule // sfr_host_properties

bind sfr_host sfr_host_properties #(.HALF_CYC(HALF_CYC), .LOW_CYC(LOW_CYC)) u_props (
  .clk_sys(clk_sys),
  .sys_rst(sys_rst),
  .chipSelectActiveLow(chipSelectActiveLow),
  .serialClock(serialClock),
  .serialOut(serialOut),
  .sleepPinActiveLow(sleepPinActiveLow)
);

// File: sim/sfr_dev_model.sv
`timescale 1ns/10ps

// ----------------------------------------
// Behavioural device on the serial link
// ----------------------------------------
module sfr_dev_model #(
  parameter logic [5:0] CLR_ADDR = 6'h03,
  parameter real RST_MAX_NS = 2000.0
) (
  // Link and sleep pin.
  input wire logic chipSelectActiveLow,
  input wire logic serialClock,
  input wire logic dataIn,
  input wire logic sleepPinActiveLow,
  output logic dataOut
);
  logic [7:0] regs [0:12];
  logic [2:0] errFlags;
  logic [15:0] inWord, respWord;
  int cnt = -1;
  realtime lowAt = 0;

  function automatic logic [7:0] view(input logic [5:0] a);
    if (a == 6'h00) return {2'h0, |errFlags, 5'h00};
    if (a == 6'h02) return {5'h00, errFlags};
    if (a > 6'h0C) return 8'h00;
    return regs[a];
  endfunction

  task automatic wipe();
    foreach (regs[i]) regs[i] = 8'h00;
    errFlags = 3'h0;
  endtask
  initial begin
    wipe();
    dataOut = 1'h0;
  end

  // short low clears faults, long low sleeps
  always @(negedge sleepPinActiveLow) lowAt = $realtime;
  always @(posedge sleepPinActiveLow) begin
    if ($realtime - lowAt <= RST_MAX_NS) errFlags = 3'h0;
    else wipe();
  end

  // status byte taken at select, first bit ready before first fall
  always @(negedge chipSelectActiveLow) begin
    cnt = 0;
    respWord = {view(6'h00), 8'h00};
    dataOut = respWord[15];
  end

  // sample on the falling clock; the address is whole after seven bits
  always @(negedge serialClock) if (!chipSelectActiveLow && cnt >= 0) begin
    inWord = {inWord[14:0], dataIn};
    cnt++;
    if (cnt == 7) respWord[7:0] = view(inWord[5:0]);
  end

  // launch on the rising clock, old content before any update
  always @(posedge serialClock) if (!chipSelectActiveLow && cnt < 16) begin
    dataOut = respWord[15 - cnt];
  end

  // act only on a whole, clean frame
  always @(posedge chipSelectActiveLow) if (cnt >= 0) begin
    // released line shows no stale level
    dataOut = ~dataOut;
    if (cnt != 16) errFlags[1] = 1'h1;
    else if (^inWord) errFlags[2] = 1'h1;
    else if (inWord[14:9] > 6'h0C) errFlags[0] = 1'h1;
    else if (!inWord[15]) begin
      if (inWord[14:9] == CLR_ADDR && inWord[0]) errFlags = 3'h0;
      if (inWord[14:9] > 6'h02) regs[inWord[14:9]] = inWord[7:0];
    end
    cnt = -1;
  end
endmodule // sfr_dev_model

// File: sim/testbench.sv
`timescale 1ns/10ps
`include "sfr_cfg.svh"

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end

// ----------------------------------------
// Controller bench
// ----------------------------------------
module testbench;
  localparam logic [5:0] CLR_LOC = 6'h03;
  logic clk_sys, sys_rst, regWr, regRd, serialIn;
  logic [3:0] regAddr;
  logic [15:0] regWdata, regRdata, got;
  logic chipSelectActiveLow, serialClock, serialOut, sleepPinActiveLow;
  int err_count, checks;

  sfr_host #(.HALF_CYC(4), .LOW_CYC(10)) u_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .chipSelectActiveLow(chipSelectActiveLow), .serialClock(serialClock),
    .serialOut(serialOut), .serialIn(serialIn), .sleepPinActiveLow(sleepPinActiveLow));
  sfr_dev_model #(.CLR_ADDR(CLR_LOC)) u_dev (
    .chipSelectActiveLow(chipSelectActiveLow), .serialClock(serialClock),
    .dataIn(serialOut), .sleepPinActiveLow(sleepPinActiveLow), .dataOut(serialIn));

  // Clock at 10 MHz.
  initial begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'h1;
    @(posedge clk_sys);
    regWr <= 1'h0;
  endtask

  // Plain read; the data stand only in the cycle after the strobe.
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge clk_sys);
    regRd <= 1'h0;
    @(negedge clk_sys);
    got = regRdata;
  endtask

  // Read and compare against the expected word.
  task automatic rdc(input logic [3:0] a, input logic [15:0] e, input string nm);
    rd(a);
    `CHK(nm, e, got)
  endtask

  // One frame; the parity bit is left 0 on purpose, hardware must set it.
  task automatic frame(input logic [15:0] w, input logic [15:0] e);
    wr(`SFR_OFF_CMD, w);
    wr(`SFR_OFF_CTRL, 16'h0001);
    repeat (3) @(posedge clk_sys);
    got = 16'h0001;
    // Polling only watches busy; a frame that never ends is caught just below.
    for (int i = 0; i < 400 && got[0] !== 1'h0; i++) rd(`SFR_OFF_STATUS);
    `CHK("busy", 1'h0, got[0])
    `CHK("done", 1'h1, got[1])
    rdc(`SFR_OFF_RESP, e, "resp");
  endtask

  task automatic final_report();
    if (err_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence.
  initial begin
    sys_rst = 1'h1;
    {regWr, regRd, regAddr, regWdata} = '0;
    err_count = 0;
    checks = 0;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'h0;
    rdc(`SFR_OFF_SUMMARY, 16'h0000, "summary");
    rdc(4'hF, 16'h0000, "hole");
    frame({1'h1, 6'h00, 9'h000}, 16'h0000);
    frame({1'h0, 6'h05, 1'h0, 8'hA5}, 16'h0000);
    frame({1'h0, 6'h05, 1'h0, 8'h5A}, 16'h00A5);
    frame({1'h1, 6'h05, 9'h000}, 16'h005A);
    frame({1'h0, 6'h00, 1'h0, 8'hFF}, 16'h0000);
    frame({1'h1, 6'h00, 9'h000}, 16'h0000);
    frame({1'h1, 6'h02, 9'h000}, 16'h0000);
    frame({1'h1, 6'h0D, 9'h000}, 16'h0000);
    frame({1'h1, 6'h02, 9'h000}, 16'h2001);
    rdc(`SFR_OFF_POWER, 16'h0001, "power");
    rd(`SFR_OFF_STATUS);
    `CHK("flags", 4'h3, got[7:4])
    wr(`SFR_OFF_CTRL, 16'h0002);
    repeat (15) @(posedge clk_sys);
    frame({1'h1, 6'h02, 9'h000}, 16'h0000);
    frame({1'h1, 6'h05, 9'h000}, 16'h005A);
    rdc(`SFR_OFF_CMD, 16'h8B00, "cmd");
    frame({1'h1, 6'h3F, 9'h000}, 16'h0000);
    frame({1'h0, CLR_LOC, 1'h0, 8'h01}, 16'h2000);
    frame({1'h1, 6'h02, 9'h000}, 16'h0000);
    final_report();
  end

  // Watchdog well beyond the expected run.
  initial begin
    #3000000;
    err_count++;
    final_report();
  end
endmodule // testbench
